// ==== verilog/uaf_pkg.sv ====
// Constants and types shared by the FIFO control block.
// Assumes an 8-bit parallel register bus with a 3-bit address.
package uaf_pkg;
    // ========================================
    // Register addresses
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IEN = 3'h1;
    localparam logic [2:0] ADR_IID = 3'h2;
    localparam logic [2:0] ADR_LCR = 3'h3;
    localparam logic [2:0] ADR_MCR = 3'h4;
    localparam logic [2:0] ADR_LSR = 3'h5;
    localparam logic [2:0] ADR_MSR = 3'h6;
    localparam logic [2:0] ADR_SCR = 3'h7;
    // ========================================
    // Field positions
    localparam int FC_EN = 0;
    localparam int FC_RXCLR = 1;
    localparam int FC_TXCLR = 2;
    localparam int FC_RDYMODE = 3;
    localparam int FC_DEEP = 5;
    localparam int FC_TRIG = 6;
    localparam int LC_WLS = 0;
    localparam int LC_STB = 2;
    localparam int LC_PEN = 3;
    localparam int LC_DIVISOR_ACCESS_BIT = 7;
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LS = 2;
    localparam int IE_MS = 3;
    // ========================================
    // Reset values and masks
    localparam logic [7:0] IEN_MASK = 8'h3F;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ========================================
    // Identification codes, low nibble
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_LS = 4'h6;
    localparam logic [3:0] IID_RX = 4'h4;
    localparam logic [3:0] IID_TO = 4'hC;
    localparam logic [3:0] IID_TX = 4'h2;
    localparam logic [3:0] IID_MS = 4'h0;
    // ========================================
    // Timing: receive clock ticks per bit, character times to time-out
    localparam int BIT_TICKS = 16;
    localparam int TO_CHARS = 4;
    localparam int SHALLOW_DEPTH = 16;
    // ========================================
    // Types
    typedef struct packed {
        logic bi;
        logic fe;
        logic pe;
        logic [7:0] data;
    } uaf_rx_ent_t;
    typedef struct packed {
        logic [2:0] adr;
        logic rd;
        logic wr;
        logic [7:0] wd;
    } uaf_bus_t;
endpackage

// ==== verilog/uaf_fifo_ctrl.sv ====
// FIFO control, FIFO interrupts and FIFO status of a serial element.
// Assumes bus strobes and receiver/transmitter events on mclk; rclk is
// a foreign clock sampled as a plain input.
// How it works
// - Address 2 reads identification and writes FIFO control.
// - Control bit 0 enables FIFOs, gates other bits; toggling empties both.
// - Receive clear empties receive FIFO only and self-clears.
// - Transmit clear empties transmit FIFO, count zero, self-clears.
// - Ready-mode bit selects signalling mode 1 when FIFOs enabled.
// - Bit 5 picks 64 or 16 depth, writable only with divisor access set.
// - Bits 7:6 choose trigger 1/4/8/14 or 1/16/32/56.
// - Trigger level raises code 04, withdrawn below level.
// - Line status code 06 outranks received data code 04.
// - Data ready set on receive push, cleared when FIFO empty.
// - Time-out after four idle character times with data held.
// - Character times counted on the receive clock.
// - Reading one character clears time-out and restarts the timer.
// - Transmit FIFO empty gives code 2; write or identification read clears.
// - Empty status delayed a character less stop without two bytes seen.
// - First transmit interrupt after enable change is immediate.
// - Time-out shares receive level; transmit empty shares holding level.
// - Interrupt enable clear gives polled mode; FIFOs keep storing.
// - Status bit 6 means all transmit empty; bit 7 receive FIFO error.
// - Identification bits 7:6 read zero in compatibility mode.
// - Data bit 0 is least significant, first on the line.
// - Identification bit 0 reads zero while an interrupt pends.
// - Identification bit 3 marks time-out, zero in compatibility mode.
module uaf_fifo_ctrl
    import uaf_pkg::*;
#(
    parameter int FIFO_DEPTH = 64
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire uaf_bus_t hostReq,
    output logic [7:0] rdData_q,
    input wire logic rclk,
    input wire logic rxPush,
    input wire uaf_rx_ent_t rxEntry,
    input wire logic txTake,
    input wire logic txShiftEmpty,
    input wire logic [7:0] msrIn,
    output logic [7:0] txData_q,
    output logic txValid_q,
    output logic intrpt_q,
    output logic rxReadyOut_n_q,
    output logic txReadyOut_n_q,
    output logic [7:0] lineFormat_q,
    output logic [7:0] handshakeOut_q,
    output logic [15:0] baudDivisor_q
);
    localparam int PW = $clog2(FIFO_DEPTH);
    typedef logic [PW:0] cnt_t;

    generate
        if (FIFO_DEPTH != 64)
        begin : g_chk
            $error("FIFO_DEPTH must be 64");
        end
    endgenerate

    // ========================================
    // Control registers
    logic [7:0] ien_q;
    logic [7:0] scr_q;
    logic fifoEn_q;
    logic rdyMode_q;
    logic deep_q;
    logic [1:0] trig_q;
    logic overrun_q;

    // Bus decode
    logic divisor_access_bit;
    logic rdAcc;
    logic wrAcc;
    logic rbrRd;
    logic thrWr;
    logic iidRd;
    logic lsrRd;
    logic fcrWr;
    logic fifoChg;
    logic rxClr;
    logic txClr;
    assign divisor_access_bit = lineFormat_q[LC_DIVISOR_ACCESS_BIT];
    assign rdAcc = hostReq.rd;
    assign wrAcc = hostReq.wr;
    assign rbrRd = rdAcc && hostReq.adr == ADR_DATA && !divisor_access_bit;
    assign thrWr = wrAcc && hostReq.adr == ADR_DATA && !divisor_access_bit;
    assign iidRd = rdAcc && hostReq.adr == ADR_IID;
    assign lsrRd = rdAcc && hostReq.adr == ADR_LSR;
    assign fcrWr = wrAcc && hostReq.adr == ADR_IID;
    assign fifoChg = fcrWr && hostReq.wd[FC_EN] != fifoEn_q;
    assign rxClr = fifoChg || (fcrWr && hostReq.wd[FC_EN] && hostReq.wd[FC_RXCLR]);
    assign txClr = fifoChg || (fcrWr && hostReq.wd[FC_EN] && hostReq.wd[FC_TXCLR]);

    // FIFO control register; bit 4 is not stored
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            fifoEn_q <= 1'b0;
            rdyMode_q <= 1'b0;
            deep_q <= 1'b0;
            trig_q <= 2'h0;
        end
        else if (fcrWr)
        begin
            fifoEn_q <= hostReq.wd[FC_EN];
            if (hostReq.wd[FC_EN])
            begin
                rdyMode_q <= hostReq.wd[FC_RDYMODE];
                trig_q <= hostReq.wd[FC_TRIG +: 2];
                if (divisor_access_bit)
                    deep_q <= hostReq.wd[FC_DEEP];
            end
        end
    end

    // Plain read/write registers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ien_q <= REG_RESET;
            lineFormat_q <= REG_RESET;
            handshakeOut_q <= REG_RESET;
            scr_q <= REG_RESET;
            baudDivisor_q <= 16'h0000;
        end
        else if (wrAcc)
        begin
            unique case (hostReq.adr)
                ADR_DATA: if (divisor_access_bit) baudDivisor_q[7:0] <= hostReq.wd;
                ADR_IEN:
                    if (divisor_access_bit) baudDivisor_q[15:8] <= hostReq.wd;
                    else ien_q <= hostReq.wd & IEN_MASK;
                ADR_LCR: lineFormat_q <= hostReq.wd;
                ADR_MCR: handshakeOut_q <= hostReq.wd;
                ADR_SCR: scr_q <= hostReq.wd;
                default: ;
            endcase
        end
    end

    // ========================================
    // Receive clock sampling and character timing
    logic rclkS1_q;
    logic rclkS2_q;
    logic rclkS3_q;
    logic tick;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rclkS1_q <= 1'b0;
            rclkS2_q <= 1'b0;
            rclkS3_q <= 1'b0;
        end
        else
        begin
            rclkS1_q <= rclk;
            rclkS2_q <= rclkS1_q;
            rclkS3_q <= rclkS2_q;
        end
    end
    assign tick = rclkS2_q && !rclkS3_q;

    // Bits per character: start, data, parity, stops
    logic [3:0] charBits;
    logic [10:0] toLimit;
    logic [9:0] threLimit;
    assign charBits = 4'd7 + {2'b00, lineFormat_q[LC_WLS +: 2]} + {3'b000, lineFormat_q[LC_PEN]}
                      + {3'b000, lineFormat_q[LC_STB]};
    assign toLimit = 11'(int'(charBits) * BIT_TICKS * TO_CHARS);
    assign threLimit = 10'((int'(charBits) - 1) * BIT_TICKS);

    // ========================================
    // Receive FIFO storage
    uaf_rx_ent_t rxMem_q [FIFO_DEPTH];
    logic [PW-1:0] rxWp_q;
    logic [PW-1:0] rxRp_q;
    cnt_t rxCnt_q;
    cnt_t limit;
    cnt_t trigLvl;
    logic rxDoPush;
    logic rxDoPop;
    uaf_rx_ent_t rxHead;
    assign limit = !fifoEn_q ? cnt_t'(1) : deep_q ? cnt_t'(FIFO_DEPTH) : cnt_t'(SHALLOW_DEPTH);
    assign rxDoPush = rxPush && rxCnt_q < limit && !rxClr;
    assign rxDoPop = rbrRd && rxCnt_q != '0 && !rxClr;
    assign rxHead = rxMem_q[rxRp_q];

    // Trigger level table
    always_comb
    begin
        unique case (trig_q)
            2'h0: trigLvl = cnt_t'(1);
            2'h1: trigLvl = deep_q ? cnt_t'(16) : cnt_t'(4);
            2'h2: trigLvl = deep_q ? cnt_t'(32) : cnt_t'(8);
            2'h3: trigLvl = deep_q ? cnt_t'(56) : cnt_t'(14);
        endcase
    end

    // Receive entries; shift register content is never touched here
    generate
        for (genvar i = 0; i < FIFO_DEPTH; i++)
        begin : g_rx
            always_ff @(posedge mclk)
            begin
                if (rxDoPush && rxWp_q == PW'(i))
                    rxMem_q[i] <= rxEntry;
            end
        end
    endgenerate

    // Receive pointers and count
    logic [PW:0] rxErrCnt_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_n || rxClr)
        begin
            rxWp_q <= '0;
            rxRp_q <= '0;
            rxCnt_q <= '0;
            rxErrCnt_q <= '0;
        end
        else
        begin
            if (rxDoPush)
                rxWp_q <= rxWp_q + 1'b1;
            if (rxDoPop)
                rxRp_q <= rxRp_q + 1'b1;
            rxCnt_q <= rxCnt_q + cnt_t'(rxDoPush) - cnt_t'(rxDoPop);
            rxErrCnt_q <= rxErrCnt_q + (PW+1)'(rxDoPush && |rxEntry[10:8])
                          - (PW+1)'(rxDoPop && |rxHead[10:8]);
        end
    end

    // Overrun flag; a new overrun wins over the status read
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            overrun_q <= 1'b0;
        else if (rxPush && rxCnt_q >= limit)
            overrun_q <= 1'b1;
        else if (lsrRd)
            overrun_q <= 1'b0;
    end

    // ========================================
    // Character time-out
    logic [10:0] toCnt_q;
    logic toFlag_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_n || rxDoPush || rxDoPop || rxCnt_q == '0 || !fifoEn_q)
        begin
            toCnt_q <= '0;
            toFlag_q <= 1'b0;
        end
        else if (tick && !toFlag_q)
        begin
            if (toCnt_q >= toLimit)
                toFlag_q <= 1'b1;
            else
                toCnt_q <= toCnt_q + 1'b1;
        end
    end

    // ========================================
    // Transmit FIFO storage
    logic [7:0] txMem_q [FIFO_DEPTH];
    logic [PW-1:0] txWp_q;
    logic [PW-1:0] txRp_q;
    cnt_t txCnt_q;
    logic txDoPush;
    logic txDoPop;
    assign txDoPush = thrWr && txCnt_q < limit && !txClr;
    assign txDoPop = txTake && txCnt_q != '0 && !txClr;

    generate
        for (genvar j = 0; j < FIFO_DEPTH; j++)
        begin : g_tx
            always_ff @(posedge mclk)
            begin
                if (txDoPush && txWp_q == PW'(j))
                    txMem_q[j] <= hostReq.wd;
            end
        end
    endgenerate

    // Transmit pointers and count
    always_ff @(posedge mclk)
    begin
        if (!rst_n || txClr)
        begin
            txWp_q <= '0;
            txRp_q <= '0;
            txCnt_q <= '0;
        end
        else
        begin
            if (txDoPush)
                txWp_q <= txWp_q + 1'b1;
            if (txDoPop)
                txRp_q <= txRp_q + 1'b1;
            txCnt_q <= txCnt_q + cnt_t'(txDoPush) - cnt_t'(txDoPop);
        end
    end

    // Head of transmit FIFO toward the shifter
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            txData_q <= 8'h00;
            txValid_q <= 1'b0;
        end
        else
        begin
            txData_q <= txMem_q[txRp_q];
            txValid_q <= txCnt_q != '0 && !txDoPop;
        end
    end

    // ========================================
    // Holding-empty status with delay
    logic tx_holding_empty_flag_q;
    logic twoSeen_q;
    logic [9:0] dlyCnt_q;
    logic threSet;
    assign threSet = !tx_holding_empty_flag_q && txCnt_q == '0 && !thrWr
                     && (twoSeen_q || dlyCnt_q >= threLimit);
    always_ff @(posedge mclk)
    begin
        if (!rst_n || txClr)
            tx_holding_empty_flag_q <= 1'b1;
        else if (txDoPush)
            tx_holding_empty_flag_q <= 1'b0;
        else if (threSet)
            tx_holding_empty_flag_q <= 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n || tx_holding_empty_flag_q || txCnt_q != '0)
            dlyCnt_q <= '0;
        else if (tick)
            dlyCnt_q <= dlyCnt_q + 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n || threSet || txClr)
            twoSeen_q <= 1'b0;
        else if (txCnt_q >= cnt_t'(2))
            twoSeen_q <= 1'b1;
    end

    // ========================================
    // Interrupt sources and identification
    logic lsIrq;
    logic rxIrq;
    logic txIrq_q;
    logic msIrq;
    logic [3:0] iidCode;
    logic [3:0] lsrErr;
    logic hdRead_q;
    logic headNew;
    assign headNew = rxClr || rxDoPop || (rxDoPush && rxCnt_q == '0);
    assign lsrErr = {rxCnt_q != '0 && !hdRead_q ? rxHead[10:8] : 3'b000, overrun_q};

    // Head error bits hidden once status is read; a new head shows them again
    always_ff @(posedge mclk)
    begin
        if (!rst_n || headNew)
            hdRead_q <= 1'b0;
        else if (lsrRd)
            hdRead_q <= 1'b1;
    end
    assign lsIrq = ien_q[IE_LS] && |lsrErr;
    assign rxIrq = ien_q[IE_RX] && (fifoEn_q ? rxCnt_q >= trigLvl : rxCnt_q != '0);
    assign msIrq = ien_q[IE_MS] && |msrIn[3:0];

    // Priority encoder
    always_comb
    begin
        if (lsIrq)
            iidCode = IID_LS;
        else if (rxIrq)
            iidCode = IID_RX;
        else if (ien_q[IE_RX] && toFlag_q)
            iidCode = IID_TO;
        else if (txIrq_q && ien_q[IE_TX])
            iidCode = IID_TX;
        else if (msIrq)
            iidCode = IID_MS;
        else
            iidCode = IID_NONE;
    end

    // Transmit interrupt flag; setting wins over clearing
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            txIrq_q <= 1'b0;
        else if (ien_q[IE_TX] && (threSet || fifoChg))
            txIrq_q <= 1'b1;
        else if (thrWr || (iidRd && iidCode == IID_TX) || !ien_q[IE_TX])
            txIrq_q <= 1'b0;
    end

    // ========================================
    // Read data and outputs
    logic [7:0] lsrVal;
    assign lsrVal = {rxErrCnt_q != '0, tx_holding_empty_flag_q && txShiftEmpty, tx_holding_empty_flag_q, lsrErr, rxCnt_q != '0};
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdData_q <= 8'h00;
        else if (rdAcc)
        begin
            unique case (hostReq.adr)
                ADR_DATA: rdData_q <= divisor_access_bit ? baudDivisor_q[7:0] : rxHead.data;
                ADR_IEN: rdData_q <= divisor_access_bit ? baudDivisor_q[15:8] : ien_q;
                ADR_IID: rdData_q <= {fifoEn_q, fifoEn_q, fifoEn_q && deep_q, 1'b0,
                                      fifoEn_q ? iidCode : iidCode & 4'h7};
                ADR_LCR: rdData_q <= lineFormat_q;
                ADR_MCR: rdData_q <= handshakeOut_q;
                ADR_LSR: rdData_q <= lsrVal;
                ADR_MSR: rdData_q <= msrIn;
                ADR_SCR: rdData_q <= scr_q;
            endcase
        end
    end

    // Interrupt line active high, ready signals active low
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            intrpt_q <= 1'b0;
            rxReadyOut_n_q <= 1'b1;
            txReadyOut_n_q <= 1'b0;
        end
        else
        begin
            intrpt_q <= iidCode != IID_NONE;
            if (fifoEn_q && rdyMode_q)
            begin
                rxReadyOut_n_q <= !(rxCnt_q >= trigLvl || toFlag_q);
                txReadyOut_n_q <= txCnt_q >= limit;
            end
            else
            begin
                rxReadyOut_n_q <= rxCnt_q == '0;
                txReadyOut_n_q <= txCnt_q != '0;
            end
        end
    end
endmodule // uaf_fifo_ctrl

// ==== bench/uaf_fifo_props.sv ====
// Checker for the FIFO control block, bound onto its ports.
// Assumes one clock domain and a synchronous active-low reset.
module uaf_fifo_props
    import uaf_pkg::*;
#(
    parameter int FIFO_DEPTH = 64
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire uaf_bus_t hostReq,
    input wire logic [7:0] rdData_q,
    input wire logic rxPush,
    input wire logic txTake,
    input wire logic [7:0] txData_q,
    input wire logic txValid_q,
    input wire logic intrpt_q,
    input wire logic rxReadyOut_n_q,
    input wire logic txReadyOut_n_q,
    input wire logic [7:0] lineFormat_q,
    input wire logic [15:0] baudDivisor_q
);
    // ========================================
    // Shadow of enables and ready mode
    logic fifoOn_q;
    logic rdyMode_q;
    logic [3:0] ien_q;
    logic fcrWr;
    logic mode0;
    assign fcrWr = hostReq.wr && hostReq.adr == ADR_IID;
    assign mode0 = !(fifoOn_q && rdyMode_q);

    // Track FIFO enable and ready mode
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            fifoOn_q <= 1'b0;
            rdyMode_q <= 1'b0;
        end
        else if (fcrWr)
        begin
            fifoOn_q <= hostReq.wd[FC_EN];
            if (hostReq.wd[FC_EN])
                rdyMode_q <= hostReq.wd[FC_RDYMODE];
        end
    end

    // Track interrupt enables
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ien_q <= 4'h0;
        else if (hostReq.wr && hostReq.adr == ADR_IEN && !lineFormat_q[LC_DIVISOR_ACCESS_BIT])
            ien_q <= hostReq.wd[3:0];
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_tx_clear: assert property (fcrWr && hostReq.wd[FC_EN] && hostReq.wd[FC_TXCLR] |-> ##2 !txValid_q)
        else $error("transmit data left after clear");
    a_iid_pending: assert property (hostReq.rd && hostReq.adr == ADR_IID && intrpt_q
        && !$past(hostReq.rd) && !$past(hostReq.wr) |=> !rdData_q[0])
        else $error("identification bit 0 set while pending");
    a_rx_ready_mode0: assert property (mode0 && rxPush && !hostReq.rd && !fcrWr
        ##1 (!hostReq.rd && !fcrWr) |=> !rxReadyOut_n_q)
        else $error("receive ready not low with data");
    a_tx_ready_mode0: assert property (mode0 && $past(mode0) && !$past(txTake) |-> txReadyOut_n_q == txValid_q)
        else $error("transmit ready wrong in mode 0");
    a_polled_quiet: assert property (ien_q == 4'h0 && $past(ien_q) == 4'h0 |-> !intrpt_q)
        else $error("interrupt with all enables clear");
    a_div_low: assert property (hostReq.wr && hostReq.adr == ADR_DATA && lineFormat_q[LC_DIVISOR_ACCESS_BIT]
        |=> baudDivisor_q[7:0] == $past(hostReq.wd))
        else $error("divisor low byte not written");
    a_div_high: assert property (hostReq.wr && hostReq.adr == ADR_IEN && lineFormat_q[LC_DIVISOR_ACCESS_BIT]
        |=> baudDivisor_q[15:8] == $past(hostReq.wd))
        else $error("divisor high byte not written");
    a_div_guard: assert property (!(hostReq.wr && lineFormat_q[LC_DIVISOR_ACCESS_BIT]) |=> $stable(baudDivisor_q))
        else $error("divisor changed without access bit");
    a_tx_push: assert property ((hostReq.wr && hostReq.adr == ADR_DATA && !lineFormat_q[LC_DIVISOR_ACCESS_BIT]
        && !txValid_q && !$past(hostReq.wr) && !txTake) ##1 !txTake
        |=> txValid_q && txData_q == $past(hostReq.wd, 2))
        else $error("written byte not at transmit head");
endmodule // uaf_fifo_props

bind uaf_fifo_ctrl uaf_fifo_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.mclk(mclk), .rst_n(rst_n),
    .hostReq(hostReq), .rdData_q(rdData_q), .rxPush(rxPush), .txTake(txTake), .txData_q(txData_q),
    .txValid_q(txValid_q), .intrpt_q(intrpt_q), .rxReadyOut_n_q(rxReadyOut_n_q),
    .txReadyOut_n_q(txReadyOut_n_q), .lineFormat_q(lineFormat_q), .baudDivisor_q(baudDivisor_q));

// ==== bench/uaf_host_model.sv ====
// Host processor model: register bus reads and writes.
// Assumes read data arrives the edge after the read strobe.
module uaf_host_model
    import uaf_pkg::*;
(
    output uaf_bus_t hostReq,
    input wire logic mclk,
    input wire logic [7:0] rdData_q
);
    timeunit 1ns;
    timeprecision 100ps;
    initial hostReq = '0;

    // One write strobe, data scrambled once released
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1;
        hostReq.adr = a;
        hostReq.wd = v;
        hostReq.wr = 1'b1;
        @(posedge mclk);
        #1;
        hostReq.wr = 1'b0;
        hostReq.wd = ~v;
    endtask

    // One read strobe, data taken after the answering edge
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        #1;
        hostReq.adr = a;
        hostReq.rd = 1'b1;
        @(posedge mclk);
        #1;
        hostReq.rd = 1'b0;
        v = rdData_q;
    endtask

    // Depth select wrapped in divisor access, enable held
    task automatic deep(input logic [7:0] v);
        wr(ADR_LCR, 8'h83);
        wr(ADR_IID, v);
        wr(ADR_LCR, 8'h03);
    endtask
endmodule // uaf_host_model

// ==== bench/tb_top.sv ====
// Testbench for the FIFO control block, driven through the host model.
// Assumes the checker is bound and the host model is compiled first.
module tb_top;
    import uaf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, rclk, rxPush, txTake, txShiftEmpty, txValid, intrpt, rx_ready_out_n, tx_ready_out_n;
    uaf_bus_t hostReq;
    uaf_rx_ent_t rxEntry;
    logic [7:0] rdData, txData, lineFormat, handshakeOut, d, base;
    logic [15:0] baudDivisor;
    int errors, checkCount, cyc, k;
    int lvl [8] = '{1, 4, 8, 14, 1, 16, 32, 56};

    uaf_host_model i_host (.hostReq(hostReq), .mclk(mclk), .rdData_q(rdData));
    uaf_fifo_ctrl #(.FIFO_DEPTH(64)) i_dut (.mclk(mclk), .rst_n(rst_n), .hostReq(hostReq),
        .rdData_q(rdData), .rclk(rclk), .rxPush(rxPush), .rxEntry(rxEntry), .txTake(txTake),
        .txShiftEmpty(txShiftEmpty), .msrIn(8'h00), .txData_q(txData), .txValid_q(txValid),
        .intrpt_q(intrpt), .rxReadyOut_n_q(rx_ready_out_n), .txReadyOut_n_q(tx_ready_out_n),
        .lineFormat_q(lineFormat), .handshakeOut_q(handshakeOut), .baudDivisor_q(baudDivisor));

    // ========================================
    // Clocks and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        rclk = 1'b0;
        #13;
        forever #50 rclk = ~rclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            results();
        end
    end

    // ========================================
    // Helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic push(input int n, input logic pe);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            #1;
            rxPush = 1'b1;
            rxEntry = {1'b0, 1'b0, pe, 8'(i)};
            @(posedge mclk);
            #1;
            rxPush = 1'b0;
        end
    endtask
    task automatic iid(input logic [3:0] exp);
        i_host.rd(ADR_IID, d);
        check("iid code", d[3:0], exp);
    endtask
    task automatic take();
        @(posedge mclk);
        #1;
        txTake = 1'b1;
        @(posedge mclk);
        #1;
        txTake = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        rxPush = 1'b0;
        txTake = 1'b0;
        txShiftEmpty = 1'b1;
        rxEntry = '0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        // Reset values
        i_host.rd(ADR_IID, d);
        check("iid reset", d, 8'h01);
        i_host.rd(ADR_LSR, d);
        check("lsr reset", d, 8'h60);
        // Divisor and depth gating
        i_host.wr(ADR_LCR, 8'h83);
        i_host.wr(ADR_DATA, 8'h34);
        i_host.wr(ADR_IEN, 8'h12);
        check("divisor", baudDivisor, 16'h1234);
        i_host.wr(ADR_LCR, 8'h03);
        i_host.wr(ADR_IID, 8'h21);
        i_host.rd(ADR_IID, d);
        check("depth gated", d, 8'hC1);
        i_host.wr(ADR_IID, 8'h0E);
        i_host.rd(ADR_IID, d);
        check("fifo off", d, 8'h01);
        // Trigger levels in both depths
        for (k = 0; k < 8; k++)
        begin
            if (k % 4 == 0)
            begin
                base = (k != 0) ? 8'hE0 : 8'hC0;
                i_host.deep((k != 0) ? 8'h21 : 8'h01);
                i_host.wr(ADR_IEN, 8'h01);
            end
            i_host.wr(ADR_IID, 8'h13 | 8'((k % 4) << 6));
            push(lvl[k] - 1, 1'b0);
            i_host.rd(ADR_IID, d);
            check("below trigger", d, base | 8'h01);
            push(1, 1'b0);
            i_host.rd(ADR_IID, d);
            check("at trigger", d, base | 8'h04);
            check("rx irq", intrpt, 1'b1);
            i_host.rd(ADR_DATA, d);
            check("rx head", d, 8'h00);
            iid(4'h1);
        end
        // Line status outranks data
        i_host.wr(ADR_IEN, 8'h05);
        i_host.wr(ADR_IID, 8'h03);
        push(1, 1'b1);
        iid(4'h6);
        i_host.rd(ADR_LSR, d);
        check("lsr error", d & 8'h81, 8'h81);
        iid(4'h4);
        i_host.rd(ADR_DATA, d);
        i_host.rd(ADR_LSR, d);
        check("lsr empty", d & 8'h81, 8'h00);
        // Character time-out on the receive clock
        i_host.wr(ADR_IEN, 8'h01);
        i_host.wr(ADR_IID, 8'hC3);
        push(1, 1'b0);
        repeat (2300) @(posedge mclk);
        iid(4'h1);
        repeat (600) @(posedge mclk);
        iid(4'hC);
        check("timeout irq", intrpt, 1'b1);
        i_host.rd(ADR_DATA, d);
        iid(4'h1);
        // Polled receive
        i_host.wr(ADR_IEN, 8'h00);
        push(1, 1'b0);
        repeat (2900) @(posedge mclk);
        iid(4'h1);
        check("polled irq", intrpt, 1'b0);
        i_host.rd(ADR_LSR, d);
        check("polled ready", d & 8'h01, 8'h01);
        // Ready signalling modes
        i_host.wr(ADR_IID, 8'h43);
        push(1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        check("ready mode 0", rx_ready_out_n, 1'b0);
        i_host.wr(ADR_IID, 8'h4B);
        push(1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        check("ready mode 1", rx_ready_out_n, 1'b1);
        check("tx ready mode 1", tx_ready_out_n, 1'b0);
        i_host.wr(ADR_IID, 8'h03);
        // Transmit empty interrupt and delay
        i_host.wr(ADR_IEN, 8'h02);
        i_host.wr(ADR_IID, 8'h00);
        i_host.wr(ADR_IID, 8'h01);
        check("tx irq", intrpt, 1'b1);
        iid(4'h2);
        iid(4'h1);
        i_host.wr(ADR_DATA, 8'hA5);
        txShiftEmpty = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("tx valid", txValid, 1'b1);
        check("tx data", txData, 8'hA5);
        i_host.rd(ADR_LSR, d);
        check("lsr busy", d & 8'h60, 8'h00);
        take();
        txShiftEmpty = 1'b1;
        repeat (20) @(posedge mclk);
        iid(4'h1);
        repeat (700) @(posedge mclk);
        iid(4'h2);
        i_host.wr(ADR_DATA, 8'h01);
        i_host.wr(ADR_DATA, 8'h02);
        take();
        take();
        repeat (4) @(posedge mclk);
        iid(4'h2);
        // Transmit clear
        i_host.wr(ADR_DATA, 8'h33);
        i_host.wr(ADR_IID, 8'h05);
        repeat (3) @(posedge mclk);
        #1;
        check("tx cleared", txValid, 1'b0);
        results();
    end
endmodule // tb_top
